// file: logic/vec_irq_pkg.sv
// shared constants, states and carriers of the interrupt unit
`default_nettype none
package vec_irq_pkg;
    // ****************************************
    // register indices
    // ****************************************
    localparam logic [3:0] REG_NMI_STAT = 4'h0;
    localparam logic [3:0] REG_NMI_CTRL = 4'h1;
    localparam logic [3:0] REG_VECTOR = 4'h2;
    localparam logic [3:0] REG_MASK_LO = 4'h3;
    localparam logic [3:0] REG_MASK_HI = 4'h4;
    localparam logic [3:0] REG_RAW_LO = 4'h5;
    localparam logic [3:0] REG_RAW_HI = 4'h6;
    localparam logic [3:0] REG_DT_BASE = 4'h7;
    localparam logic [3:0] REG_ISP = 4'h8;
    localparam logic [3:0] REG_PSW = 4'h9;
    // ****************************************
    // fields and reset values
    // ****************************************
    localparam int CTRL_ONESHOT = 0;
    localparam int CTRL_PIN = 1;
    localparam int CTRL_STICKY = 2;
    localparam int PSW_T = 1;
    localparam int PSW_E = 9;
    localparam int PSW_P = 10;
    localparam int PSW_I = 11;
    localparam logic [15:0] PSW_RESET = 16'h0200;
    localparam logic [15:0] MASK_RESET = 16'hFFFF;
    localparam logic [15:0] ISP_RESET = 16'h0000;
    localparam logic [15:0] STACK_STEP = 16'h0004;
    localparam logic [4:0] NMI_VEC = 5'h01;
    localparam logic [4:0] MASKABLE_VEC_BASE = 5'h10;
    // ****************************************
    // types
    // ****************************************
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_PUSH = 6'h02,
        ST_FETCH = 6'h04,
        ST_LOAD = 6'h08,
        ST_POP = 6'h10,
        ST_RESTORE = 6'h20
    } entry_state_e;
    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;
    typedef struct packed {
        logic [20:0] addr;
        logic [31:0] wdata;
        logic we;
        logic re;
    } mem_req_s;
endpackage
`default_nettype wire

// file: logic/vectored_interrupt_unit.sv
// interrupt control unit with core entry and return sequencing
//
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - on entry lower stack pointer by four, push program counter and status
// - on entry clear global enable, trace-pending and trace status bits
// - fetch routine start at table base plus twice the vector, load it
// - return restores program counter and status, raises stack pointer by four
// - routine address is the entry with four zero bits above and one below
// - table base is 21 bits, top five and lowest bit zero
// - vectors 0 to 31; non-maskable is 1, request n is 16 plus n
// - non-maskable pin synchronised inside; falling edge raises a trap
// - after reset non-maskable traps off until an arm bit is set
// - each non-maskable trap clears the one-shot arm bit, except when a control write sets that bit in the same cycle
// - sticky arm bit is cleared only by reset
// - with sticky arm every falling edge traps, nesting allowed
// - with sticky arm the one-shot bit is ignored
// - sixteen requests in fixed priority, 15 highest, 0 lowest
// - accept request only with peripheral, mask, local and global enables
// - local enable set by load and by atomic on/off instructions
// - vector register holds 16 plus winning request, tracks the winner
// - status flag set by a non-maskable request, cleared by read
// - both mask registers reset to all ones
// - raw state shows active requests even when masked
module vectored_interrupt_unit (
    input wire logic clk,
    input wire logic rstn,
    input wire logic clk_en,
    input wire vec_irq_pkg::reg_req_s reg_req,
    output logic [15:0] reg_rdata,
    input wire logic [15:0] irq_req,
    input wire logic [15:0] irq_periph_en,
    input wire logic nmi_pin_n,
    input wire logic [20:0] core_pc,
    input wire logic core_exception_return_instr,
    input wire logic core_irq_on,
    input wire logic core_irq_off,
    input wire logic core_lpr,
    input wire logic [15:0] core_lpr_data,
    output vec_irq_pkg::mem_req_s mem_req,
    input wire logic [31:0] mem_rdata,
    output logic pc_load,
    output logic [20:0] pc_new,
    output logic [15:0] psw_out
);
    // ****************************************
    // state
    // ****************************************
    vec_irq_pkg::entry_state_e st_reg;
    logic [15:0] psw_reg;
    logic [15:0] isp_reg;
    logic [15:1] base_reg;
    logic [15:0] mask_reg;
    logic [15:0] raw_reg;
    logic [4:0] win_vec_reg;
    logic win_any_reg;
    logic [4:0] serve_vec_reg;
    logic sync1_reg, sync2_reg, pin_prev_reg;
    logic oneshot_reg, sticky_reg, nmi_pend_reg, seen_reg;
    logic [4:0] best_vec;
    logic best_any;
    logic nmi_edge, nmi_trap, take, wr_ctrl;
    logic [15:0] enabled;

    assign wr_ctrl = reg_req.wr && reg_req.addr == vec_irq_pkg::REG_NMI_CTRL;
    assign nmi_edge = pin_prev_reg && !sync2_reg;
    // sticky overrides one-shot entirely
    assign nmi_trap = nmi_edge && (sticky_reg || oneshot_reg);
    assign take = st_reg == vec_irq_pkg::ST_IDLE && !core_exception_return_instr &&
        (nmi_pend_reg || (win_any_reg && psw_reg[vec_irq_pkg::PSW_E] &&
        psw_reg[vec_irq_pkg::PSW_I]));
    assign enabled = irq_req & irq_periph_en & mask_reg;

    // ****************************************
    // priority encoder
    // ****************************************
    always_comb begin
        best_vec = 5'h00;
        best_any = 1'b0;
        for (int i = 0; i < 16; i++) begin
            if (enabled[i]) begin
                best_vec = vec_irq_pkg::MASKABLE_VEC_BASE | 5'(i);
                best_any = 1'b1;
            end
        end
    end

    // frozen outside idle so a late change cannot corrupt the fetch
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            win_vec_reg <= 5'h00;
            win_any_reg <= 1'b0;
            raw_reg <= 16'h0000;
        end else if (clk_en) begin
            raw_reg <= irq_req;
            if (st_reg == vec_irq_pkg::ST_IDLE) begin
                win_vec_reg <= best_vec;
                win_any_reg <= best_any;
            end
        end
    end

    // ****************************************
    // non-maskable pin
    // ****************************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sync1_reg <= 1'b1;
            sync2_reg <= 1'b1;
            pin_prev_reg <= 1'b1;
        end else if (clk_en) begin
            sync1_reg <= nmi_pin_n;
            sync2_reg <= sync1_reg;
            pin_prev_reg <= sync2_reg;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            oneshot_reg <= 1'b0;
            sticky_reg <= 1'b0;
        end else if (clk_en) begin
            if (wr_ctrl && reg_req.wdata[vec_irq_pkg::CTRL_ONESHOT])
                oneshot_reg <= 1'b1;
            else if (nmi_trap)
                oneshot_reg <= 1'b0;
            else if (wr_ctrl)
                oneshot_reg <= 1'b0;
            if (wr_ctrl && reg_req.wdata[vec_irq_pkg::CTRL_STICKY])
                sticky_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            nmi_pend_reg <= 1'b0;
            seen_reg <= 1'b0;
        end else if (clk_en) begin
            if (nmi_trap)
                nmi_pend_reg <= 1'b1;
            else if (take)
                nmi_pend_reg <= 1'b0;
            if (nmi_trap)
                seen_reg <= 1'b1;
            else if (reg_req.rd && reg_req.addr == vec_irq_pkg::REG_NMI_STAT)
                seen_reg <= 1'b0;
        end
    end

    // ****************************************
    // entry and return sequencer
    // ****************************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_reg <= vec_irq_pkg::ST_IDLE;
            serve_vec_reg <= 5'h00;
        end else if (clk_en) begin
            unique case (st_reg)
                vec_irq_pkg::ST_IDLE: begin
                    if (core_exception_return_instr) begin
                        st_reg <= vec_irq_pkg::ST_POP;
                    end else if (take) begin
                        st_reg <= vec_irq_pkg::ST_PUSH;
                        serve_vec_reg <= nmi_pend_reg ? vec_irq_pkg::NMI_VEC
                            : win_vec_reg;
                    end
                end
                vec_irq_pkg::ST_PUSH: st_reg <= vec_irq_pkg::ST_FETCH;
                vec_irq_pkg::ST_FETCH: st_reg <= vec_irq_pkg::ST_LOAD;
                vec_irq_pkg::ST_LOAD: st_reg <= vec_irq_pkg::ST_IDLE;
                vec_irq_pkg::ST_POP: st_reg <= vec_irq_pkg::ST_RESTORE;
                vec_irq_pkg::ST_RESTORE: st_reg <= vec_irq_pkg::ST_IDLE;
                default: st_reg <= vec_irq_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            isp_reg <= vec_irq_pkg::ISP_RESET;
        end else if (clk_en) begin
            if (take)
                isp_reg <= isp_reg - vec_irq_pkg::STACK_STEP;
            else if (st_reg == vec_irq_pkg::ST_RESTORE)
                isp_reg <= isp_reg + vec_irq_pkg::STACK_STEP;
            else if (reg_req.wr && reg_req.addr == vec_irq_pkg::REG_ISP)
                isp_reg <= reg_req.wdata;
        end
    end

    // one 32-bit stack word: status high, program counter bits 16:1 low
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mem_req <= '0;
        end else if (clk_en) begin
            mem_req.we <= st_reg == vec_irq_pkg::ST_PUSH;
            mem_req.re <= st_reg == vec_irq_pkg::ST_FETCH ||
                st_reg == vec_irq_pkg::ST_POP;
            mem_req.wdata <= {psw_reg, core_pc[16:1]};
            if (st_reg == vec_irq_pkg::ST_FETCH)
                mem_req.addr <= {5'h00, base_reg, 1'b0} +
                    {15'h0000, serve_vec_reg, 1'b0};
            else
                mem_req.addr <= {5'h00, isp_reg};
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pc_load <= 1'b0;
            pc_new <= 21'h000000;
        end else if (clk_en) begin
            pc_load <= st_reg == vec_irq_pkg::ST_LOAD ||
                st_reg == vec_irq_pkg::ST_RESTORE;
            if (st_reg == vec_irq_pkg::ST_LOAD ||
                st_reg == vec_irq_pkg::ST_RESTORE)
                pc_new <= {4'h0, mem_rdata[15:0], 1'b0};
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            psw_reg <= vec_irq_pkg::PSW_RESET;
        end else if (clk_en) begin
            if (st_reg == vec_irq_pkg::ST_PUSH) begin
                psw_reg[vec_irq_pkg::PSW_I] <= 1'b0;
                psw_reg[vec_irq_pkg::PSW_P] <= 1'b0;
                psw_reg[vec_irq_pkg::PSW_T] <= 1'b0;
            end else if (st_reg == vec_irq_pkg::ST_RESTORE) begin
                psw_reg <= mem_rdata[31:16];
            end else if (core_lpr) begin
                psw_reg <= core_lpr_data;
            end else if (core_irq_on || core_irq_off) begin
                psw_reg[vec_irq_pkg::PSW_E] <= core_irq_on;
            end
        end
    end

    // ****************************************
    // register port
    // ****************************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mask_reg <= vec_irq_pkg::MASK_RESET;
            base_reg <= 15'h0000;
        end else if (clk_en && reg_req.wr) begin
            if (reg_req.addr == vec_irq_pkg::REG_MASK_LO)
                mask_reg[7:0] <= reg_req.wdata[7:0];
            if (reg_req.addr == vec_irq_pkg::REG_MASK_HI)
                mask_reg[15:8] <= reg_req.wdata[7:0];
            if (reg_req.addr == vec_irq_pkg::REG_DT_BASE)
                base_reg <= reg_req.wdata[15:1];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 16'h0000;
        end else if (clk_en) begin
            reg_rdata <= 16'h0000;
            if (reg_req.rd) begin
                unique case (reg_req.addr)
                    vec_irq_pkg::REG_NMI_STAT: reg_rdata <= {15'h0000, seen_reg};
                    vec_irq_pkg::REG_NMI_CTRL:
                        reg_rdata <= {13'h0000, sticky_reg, sync2_reg,
                            oneshot_reg};
                    vec_irq_pkg::REG_VECTOR: reg_rdata <= {11'h000, win_vec_reg};
                    vec_irq_pkg::REG_MASK_LO: reg_rdata <= {8'h00, mask_reg[7:0]};
                    vec_irq_pkg::REG_MASK_HI: reg_rdata <= {8'h00, mask_reg[15:8]};
                    vec_irq_pkg::REG_RAW_LO: reg_rdata <= {8'h00, raw_reg[7:0]};
                    vec_irq_pkg::REG_RAW_HI: reg_rdata <= {8'h00, raw_reg[15:8]};
                    vec_irq_pkg::REG_DT_BASE: reg_rdata <= {base_reg, 1'b0};
                    vec_irq_pkg::REG_ISP: reg_rdata <= isp_reg;
                    vec_irq_pkg::REG_PSW: reg_rdata <= psw_reg;
                    default: reg_rdata <= 16'h0000;
                endcase
            end
        end
    end

    assign psw_out = psw_reg;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    chk_isp_push_step: assert property (
        clk_en && take |=> isp_reg == $past(isp_reg) - 16'h0004)
        else $error("stack pointer not lowered by four");
    chk_entry_clears_i: assert property (
        clk_en && st_reg == vec_irq_pkg::ST_PUSH |=> !psw_reg[11])
        else $error("global enable not cleared on entry");
    chk_fetch_addr: assert property (
        clk_en && st_reg == vec_irq_pkg::ST_FETCH |=> mem_req.re &&
        mem_req.addr == {5'h00, base_reg, 1'b0} + {serve_vec_reg, 1'b0})
        else $error("dispatch fetch address wrong");
    chk_return_pops: assert property (
        clk_en && st_reg == vec_irq_pkg::ST_RESTORE |=>
        isp_reg == $past(isp_reg) + 16'h0004 && pc_load)
        else $error("return did not raise stack pointer");
    chk_routine_addr: assert property (
        pc_load |-> pc_new[0] == 1'b0 && pc_new[20] == 1'b0)
        else $error("routine address padding wrong");
    chk_nmi_vector: assert property (
        clk_en && take && nmi_pend_reg |=> serve_vec_reg == 5'h01)
        else $error("non-maskable vector not one");
    chk_unarmed_quiet: assert property (
        clk_en && !sticky_reg && !oneshot_reg |=> !$rose(nmi_pend_reg))
        else $error("trap raised while unarmed");
    chk_oneshot_drop: assert property (
        clk_en && nmi_trap && !wr_ctrl |=> !oneshot_reg)
        else $error("one-shot arm survived a trap");
    chk_sticky_hold: assert property (
        sticky_reg |=> sticky_reg)
        else $error("sticky arm cleared without reset");
    chk_vector_stable: assert property (
        st_reg != vec_irq_pkg::ST_IDLE |=> $stable(win_vec_reg))
        else $error("vector changed during acknowledge");
    chk_raw_follows: assert property (
        clk_en |=> raw_reg == $past(irq_req))
        else $error("raw state does not follow requests");
endmodule // vectored_interrupt_unit
`default_nettype wire

// file: test/mem_partner.sv
// memory model on the far side of the entry sequencer
`timescale 1ns/1ps
`default_nettype none
module mem_partner (
    input wire logic clk,
    input wire vec_irq_pkg::mem_req_s mem_req,
    output logic [31:0] mem_rdata
);
    // ****************************************
    // storage and answer
    // ****************************************
    logic [31:0] store [logic [20:0]];
    logic [31:0] idle_q = 32'h00000000;
    always @(posedge clk) begin
        if (mem_req.we) begin
            store[mem_req.addr] = mem_req.wdata;
        end
        idle_q <= ~idle_q;
    end
    // answer stands while re is high: the sequencer takes it at that edge
    // outside a read the bus toggles so stale data is not reused
    always @* begin
        if (mem_req.re && store.exists(mem_req.addr)) begin
            mem_rdata = store[mem_req.addr];
        end else if (mem_req.re) begin
            // unwritten table words point inside program memory
            mem_rdata = {16'h0000, 4'h1, mem_req.addr[12:1]};
        end else begin
            mem_rdata = idle_q;
        end
    end
endmodule // mem_partner
`default_nettype wire

// file: test/tb.sv
// self-checking bench of the interrupt unit
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk, rstn, clk_en, nmi_pin_n, pc_load, rd_seen;
    logic core_exception_return_instr, core_irq_on, core_irq_off, core_lpr;
    vec_irq_pkg::reg_req_s reg_req;
    vec_irq_pkg::mem_req_s mem_req;
    logic [15:0] reg_rdata, irq_req, irq_periph_en, psw_out, core_lpr_data;
    logic [15:0] psw_m, isp_m, r16;
    logic [20:0] core_pc, pc_new;
    logic [31:0] mem_rdata, seed;
    logic [15:0] exp_rd[$];
    logic [52:0] exp_wr[$];
    logic [36:0] exp_pc[$], stk[$];
    int mismatches, check_count;
    vectored_interrupt_unit dut (.clk(clk), .rstn(rstn), .clk_en(clk_en),
        .reg_req(reg_req), .reg_rdata(reg_rdata), .irq_req(irq_req),
        .irq_periph_en(irq_periph_en), .nmi_pin_n(nmi_pin_n),
        .core_pc(core_pc), .core_exception_return_instr(core_exception_return_instr), .core_irq_on(core_irq_on),
        .core_irq_off(core_irq_off), .core_lpr(core_lpr),
        .core_lpr_data(core_lpr_data), .mem_req(mem_req),
        .mem_rdata(mem_rdata), .pc_load(pc_load), .pc_new(pc_new),
        .psw_out(psw_out));
    mem_partner far_mem (.clk(clk), .mem_req(mem_req), .mem_rdata(mem_rdata));
    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [4:0] top_vec(input logic [15:0] v);
        top_vec = 5'h00;
        for (int i = 0; i < 16; i++) if (v[i]) top_vec = 5'h10 + i[4:0];
    endfunction
    task automatic chk(input logic [52:0] g, input logic [52:0] e,
                       input string m);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic settle();
        int n;
        n = 0;
        while ((exp_pc.size() + exp_wr.size() + exp_rd.size()) != 0 && n < 80) begin
            @(posedge clk);
            n++;
        end
        if (n >= 80) begin
            mismatches++;
            $display("unexpected at %0t: no response", $time);
            conclude();
        end
    endtask
    // read: d is the expected answer
    task automatic reg_op(input logic w, input logic [3:0] a,
                          input logic [15:0] d);
        @(posedge clk);
        if (!w) exp_rd.push_back(d);
        reg_req <= '{addr: a, wdata: d, wr: w, rd: !w};
        @(posedge clk);
        reg_req.wr <= 1'b0;
        reg_req.rd <= 1'b0;
    endtask
    task automatic core_pulse(input logic [1:0] k);
        @(posedge clk);
        case (k)
            2'd0: core_exception_return_instr <= 1'b1;
            2'd1: core_irq_on <= 1'b1;
            2'd2: core_irq_off <= 1'b1;
            default: core_lpr <= 1'b1;
        endcase
        @(posedge clk);
        {core_exception_return_instr, core_irq_on, core_irq_off, core_lpr} <= 4'h0;
    endtask
    task automatic nmi_edge();
        @(posedge clk);
        nmi_pin_n <= 1'b0;
        repeat (6) @(posedge clk);
        nmi_pin_n <= 1'b1;
        repeat (6) @(posedge clk);
    endtask
    // table base fixed at 2000 by the setup below
    task automatic expect_entry(input logic [4:0] vec);
        logic [20:0] ta, cp;
        logic [31:0] r;
        r = rnd();
        cp = {4'h0, r[16:1], 1'b0};
        core_pc <= cp;
        isp_m = isp_m - 16'h0004;
        exp_wr.push_back({5'h00, isp_m, psw_m, cp[16:1]});
        stk.push_back({psw_m, cp});
        psw_m = psw_m & 16'hF3FD;
        ta = 21'h002000 + {15'h0000, vec, 1'b0};
        exp_pc.push_back({psw_m, 4'h0, 4'h1, ta[12:1], 1'b0});
    endtask
    task automatic do_exception_return_instr();
        isp_m = isp_m + 16'h0004;
        {psw_m, core_pc} = stk.pop_back();
        exp_pc.push_back({psw_m, core_pc});
        core_pulse(2'd0);
    endtask
    // ****************************************
    // output watcher
    // ****************************************
    always @(negedge clk) begin
        if (rd_seen)
            chk({37'h0, reg_rdata},
                {37'h0, exp_rd.size() ? exp_rd.pop_front() : 16'hxxxx},
                "read data");
        rd_seen = reg_req.rd;
        if (mem_req.we)
            chk({mem_req.addr, mem_req.wdata},
                exp_wr.size() ? exp_wr.pop_front() : 'x, "stack push");
        if (pc_load)
            chk({16'h0, psw_out, pc_new},
                {16'h0, exp_pc.size() ? exp_pc.pop_front() : 37'hx},
                "pc load");
    end
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {rstn, core_exception_return_instr, core_irq_on, core_irq_off, core_lpr, rd_seen} = '0;
        {reg_req, irq_req, irq_periph_en, core_pc, core_lpr_data} = '0;
        {clk_en, nmi_pin_n} = 2'b11;
        {mismatches, check_count} = '0;
        seed = 32'h0000004F;
        psw_m = 16'h0200;
        isp_m = 16'h0000;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        reg_op(1'b0, vec_irq_pkg::REG_MASK_LO, 16'h00FF);
        reg_op(1'b0, vec_irq_pkg::REG_MASK_HI, 16'h00FF);
        reg_op(1'b0, vec_irq_pkg::REG_NMI_CTRL, 16'h0002);
        reg_op(1'b0, 4'hF, 16'h0000);
        reg_op(1'b1, vec_irq_pkg::REG_ISP, 16'h0400);
        isp_m = 16'h0400;
        reg_op(1'b1, vec_irq_pkg::REG_DT_BASE, 16'h2001);
        reg_op(1'b0, vec_irq_pkg::REG_DT_BASE, 16'h2000);
        reg_op(1'b1, vec_irq_pkg::REG_MASK_LO, 16'h0000);
        reg_op(1'b1, vec_irq_pkg::REG_MASK_HI, 16'h0000);
        r16 = rnd();
        irq_req <= r16;
        reg_op(1'b0, vec_irq_pkg::REG_RAW_LO, {8'h00, r16[7:0]});
        reg_op(1'b0, vec_irq_pkg::REG_RAW_HI, {8'h00, r16[15:8]});
        reg_op(1'b1, vec_irq_pkg::REG_MASK_LO, 16'h00FF);
        irq_periph_en <= 16'hFFFF;
        // local enable on, global off: vector tracks without entry
        for (int k = 0; k < 8; k++) begin
            r16 = rnd();
            irq_req <= r16 | 16'h0001;
            repeat (3) @(posedge clk);
            // upper mask byte is still zero here
            reg_op(1'b0, vec_irq_pkg::REG_VECTOR,
                {11'h0, top_vec((r16 | 16'h0001) & 16'h00FF)});
        end
        irq_req <= 16'h8421;
        repeat (3) @(posedge clk);
        reg_op(1'b0, vec_irq_pkg::REG_VECTOR, 16'h0015);
        irq_periph_en <= 16'hFFDF;
        repeat (3) @(posedge clk);
        reg_op(1'b0, vec_irq_pkg::REG_VECTOR, 16'h0010);
        reg_op(1'b1, vec_irq_pkg::REG_MASK_HI, 16'h00FF);
        irq_periph_en <= 16'hFFFF;
        irq_req <= 16'h0240;
        core_lpr_data <= 16'h0E02;
        psw_m = 16'h0E02;
        expect_entry(5'h19);
        core_pulse(2'd3);
        settle();
        irq_req <= 16'h0000;
        reg_op(1'b0, vec_irq_pkg::REG_ISP, 16'h03FC);
        reg_op(1'b0, vec_irq_pkg::REG_PSW, psw_m);
        do_exception_return_instr();
        settle();
        reg_op(1'b0, vec_irq_pkg::REG_ISP, 16'h0400);
        core_pulse(2'd2);
        psw_m = 16'h0C02;
        irq_req <= 16'h0008;
        repeat (10) @(posedge clk);
        reg_op(1'b0, vec_irq_pkg::REG_PSW, psw_m);
        psw_m = 16'h0E02;
        expect_entry(5'h13);
        core_pulse(2'd1);
        settle();
        irq_req <= 16'h0000;
        do_exception_return_instr();
        settle();
        nmi_edge();
        reg_op(1'b1, vec_irq_pkg::REG_NMI_CTRL, 16'h0001);
        expect_entry(vec_irq_pkg::NMI_VEC);
        nmi_edge();
        settle();
        reg_op(1'b0, vec_irq_pkg::REG_NMI_STAT, 16'h0001);
        reg_op(1'b0, vec_irq_pkg::REG_NMI_STAT, 16'h0000);
        reg_op(1'b0, vec_irq_pkg::REG_NMI_CTRL, 16'h0002);
        nmi_edge();
        // handler re-arms the one-shot before returning
        reg_op(1'b1, vec_irq_pkg::REG_NMI_CTRL, 16'h0001);
        reg_op(1'b0, vec_irq_pkg::REG_NMI_CTRL, 16'h0003);
        do_exception_return_instr();
        settle();
        reg_op(1'b1, vec_irq_pkg::REG_NMI_CTRL, 16'h0004);
        reg_op(1'b1, vec_irq_pkg::REG_NMI_CTRL, 16'h0000);
        reg_op(1'b0, vec_irq_pkg::REG_NMI_CTRL, 16'h0006);
        expect_entry(vec_irq_pkg::NMI_VEC);
        nmi_edge();
        settle();
        expect_entry(vec_irq_pkg::NMI_VEC);
        nmi_edge();
        settle();
        do_exception_return_instr();
        settle();
        do_exception_return_instr();
        settle();
        reg_op(1'b0, vec_irq_pkg::REG_ISP, 16'h0400);
        settle();
        conclude();
    end
endmodule // tb
`default_nettype wire
